/* src/dtd_pkg.sv */
package dtd_pkg;

    // opcode bytes of the decoded data-transfer group
    localparam logic [7:0] OPC_SEG_FROM_RM  = 8'h8E;
    localparam logic [7:0] OPC_SEG_TO_RM    = 8'h8C;
    localparam logic [7:0] OPC_TABLE_LOOKUP = 8'hD7;
    localparam logic [7:0] OPC_EA_LOAD      = 8'h8D;
    localparam logic [7:0] OPC_PTR_DATA_SEG = 8'hC5;
    localparam logic [7:0] OPC_PTR_EXTRA    = 8'hC4;
    localparam logic [7:0] OPC_FLAGS_TO_AH  = 8'h9F;
    localparam logic [7:0] OPC_AH_TO_FLAGS  = 8'h9E;

    // field positions
    localparam int SIZE_BIT      = 0;
    localparam int SENSE_BIT     = 1;
    localparam int MOD_HI        = 7;
    localparam int MOD_LO        = 6;
    localparam int REG_HI        = 5;
    localparam int REG_LO        = 3;
    localparam int SEG_ZERO_BIT  = 5;
    localparam int SEG_HI        = 4;
    localparam int SEG_LO        = 3;
    localparam int RM_HI         = 2;
    localparam int RM_LO         = 0;

    localparam logic [3:0] OP_RESET = 4'h0;

    typedef enum logic [3:0] {
        DTD_OP_NONE         = 4'h0,
        DTD_OP_SEG_FROM_RM  = 4'h1,
        DTD_OP_SEG_TO_RM    = 4'h2,
        DTD_OP_TABLE_LOOKUP = 4'h3,
        DTD_OP_EA_LOAD      = 4'h4,
        DTD_OP_PTR_DATA_SEG = 4'h5,
        DTD_OP_PTR_EXTRA    = 4'h6,
        DTD_OP_FLAGS_TO_AH  = 4'h7,
        DTD_OP_AH_TO_FLAGS  = 4'h8
    } dtd_op_t;

    typedef enum logic [1:0] {
        DTD_ST_OPCODE = 2'b01,
        DTD_ST_MODRM  = 2'b10
    } dtd_state_t;

endpackage : dtd_pkg

/* src/dtd_decoder.sv */
`timescale 1ns/1ps
// How it works
// - opcode 8E copies register or memory into a segment register, second byte mod,0,seg,r/m.
// - opcode 8C copies a segment register into register or memory, same second-byte layout.
// - single byte D7 is the table lookup that replaces the low accumulator byte.
// - opcode 8D plus an addressing byte loads the effective address into a general register.
// - opcode C5 plus an addressing byte loads a pointer into a register and the data segment.
// - opcode C4 plus an addressing byte loads a pointer into a register and the extra segment.
// - single byte 9F copies the flags into the high accumulator byte.
// - single byte 9E stores the high accumulator byte into the flags.
module dtd_decoder (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   byte_valid,
    input  wire logic [7:0]             byte_data,
    output logic                        dec_valid,
    output dtd_pkg::dtd_op_t            dec_op,
    output logic                        dec_word,
    output logic                        dec_reg_is_dest,
    output logic                        dec_has_modrm,
    output logic [1:0]                  dec_mod,
    output logic [2:0]                  dec_reg,
    output logic [1:0]                  dec_seg,
    output logic [2:0]                  dec_rm,
    output logic                        dec_illegal,
    output logic                        dec_unknown
);

    dtd_pkg::dtd_state_t state_q, state_d;
    dtd_pkg::dtd_op_t    pend_op_q, pend_op_d;
    logic [7:0]          pend_opc_q, pend_opc_d;

    logic                valid_q, valid_d;
    dtd_pkg::dtd_op_t    op_q, op_d;
    logic                word_q, word_d;
    logic                dest_q, dest_d;
    logic                modrm_q, modrm_d;
    logic [1:0]          mod_q, mod_d;
    logic [2:0]          reg_q, reg_d;
    logic [1:0]          seg_q, seg_d;
    logic [2:0]          rm_q, rm_d;
    logic                ill_q, ill_d;
    logic                unk_q, unk_d;

    always_comb begin
        state_d    = state_q;
        pend_op_d  = pend_op_q;
        pend_opc_d = pend_opc_q;
        valid_d    = 1'b0;
        op_d       = op_q;
        word_d     = word_q;
        dest_d     = dest_q;
        modrm_d    = modrm_q;
        mod_d      = mod_q;
        reg_d      = reg_q;
        seg_d      = seg_q;
        rm_d       = rm_q;
        ill_d      = 1'b0;
        unk_d      = 1'b0;
        case (state_q)
            dtd_pkg::DTD_ST_OPCODE: begin
                if (byte_valid) begin
                    pend_opc_d = byte_data;
                    case (byte_data)
                        dtd_pkg::OPC_SEG_FROM_RM: begin
                            pend_op_d = dtd_pkg::DTD_OP_SEG_FROM_RM;
                            state_d   = dtd_pkg::DTD_ST_MODRM;
                        end
                        dtd_pkg::OPC_SEG_TO_RM: begin
                            pend_op_d = dtd_pkg::DTD_OP_SEG_TO_RM;
                            state_d   = dtd_pkg::DTD_ST_MODRM;
                        end
                        dtd_pkg::OPC_EA_LOAD: begin
                            pend_op_d = dtd_pkg::DTD_OP_EA_LOAD;
                            state_d   = dtd_pkg::DTD_ST_MODRM;
                        end
                        dtd_pkg::OPC_PTR_DATA_SEG: begin
                            pend_op_d = dtd_pkg::DTD_OP_PTR_DATA_SEG;
                            state_d   = dtd_pkg::DTD_ST_MODRM;
                        end
                        dtd_pkg::OPC_PTR_EXTRA: begin
                            pend_op_d = dtd_pkg::DTD_OP_PTR_EXTRA;
                            state_d   = dtd_pkg::DTD_ST_MODRM;
                        end
                        dtd_pkg::OPC_TABLE_LOOKUP: begin
                            op_d    = dtd_pkg::DTD_OP_TABLE_LOOKUP;
                            valid_d = 1'b1;
                        end
                        dtd_pkg::OPC_FLAGS_TO_AH: begin
                            op_d    = dtd_pkg::DTD_OP_FLAGS_TO_AH;
                            valid_d = 1'b1;
                        end
                        dtd_pkg::OPC_AH_TO_FLAGS: begin
                            op_d    = dtd_pkg::DTD_OP_AH_TO_FLAGS;
                            valid_d = 1'b1;
                        end
                        default: begin
                            // bytes outside this group are flagged, not decoded
                            op_d  = dtd_pkg::DTD_OP_NONE;
                            unk_d = 1'b1;
                        end
                    endcase
                    if (valid_d) begin
                        // the single-byte forms all move one byte of the accumulator
                        word_d  = 1'b0;
                        dest_d  = 1'b0;
                        modrm_d = 1'b0;
                        mod_d   = 2'b00;
                        reg_d   = 3'b000;
                        seg_d   = 2'b00;
                        rm_d    = 3'b000;
                    end
                end
            end
            dtd_pkg::DTD_ST_MODRM: begin
                if (byte_valid) begin
                    state_d = dtd_pkg::DTD_ST_OPCODE;
                    valid_d = 1'b1;
                    op_d    = pend_op_q;
                    modrm_d = 1'b1;
                    mod_d   = byte_data[dtd_pkg::MOD_HI:dtd_pkg::MOD_LO];
                    reg_d   = byte_data[dtd_pkg::REG_HI:dtd_pkg::REG_LO];
                    seg_d   = byte_data[dtd_pkg::SEG_HI:dtd_pkg::SEG_LO];
                    rm_d    = byte_data[dtd_pkg::RM_HI:dtd_pkg::RM_LO];
                    // segment copies and address loads move words; none of these
                    // opcodes has a size bit of its own
                    word_d  = 1'b1;
                    // only the segment copies carry a sense bit; the loads always write reg
                    dest_d  = pend_opc_q[dtd_pkg::SENSE_BIT] ||
                              !(pend_op_q == dtd_pkg::DTD_OP_SEG_FROM_RM ||
                                pend_op_q == dtd_pkg::DTD_OP_SEG_TO_RM);
                    // the segment forms need a zero in the top reg bit
                    if ((pend_op_q == dtd_pkg::DTD_OP_SEG_FROM_RM ||
                         pend_op_q == dtd_pkg::DTD_OP_SEG_TO_RM) &&
                        byte_data[dtd_pkg::SEG_ZERO_BIT]) begin
                        ill_d = 1'b1;
                    end
                    // address loads with a register operand have no address to load
                    if ((pend_op_q == dtd_pkg::DTD_OP_EA_LOAD ||
                         pend_op_q == dtd_pkg::DTD_OP_PTR_DATA_SEG ||
                         pend_op_q == dtd_pkg::DTD_OP_PTR_EXTRA) &&
                        byte_data[dtd_pkg::MOD_HI:dtd_pkg::MOD_LO] == 2'b11) begin
                        ill_d = 1'b1;
                    end
                end
            end
            default: state_d = dtd_pkg::DTD_ST_OPCODE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q    <= dtd_pkg::DTD_ST_OPCODE;
            pend_op_q  <= dtd_pkg::DTD_OP_NONE;
            pend_opc_q <= 8'h00;
            valid_q    <= 1'b0;
            op_q       <= dtd_pkg::DTD_OP_NONE;
            word_q     <= 1'b0;
            dest_q     <= 1'b0;
            modrm_q    <= 1'b0;
            mod_q      <= 2'b00;
            reg_q      <= 3'b000;
            seg_q      <= 2'b00;
            rm_q       <= 3'b000;
            ill_q      <= 1'b0;
            unk_q      <= 1'b0;
        end else begin
            state_q    <= state_d;
            pend_op_q  <= pend_op_d;
            pend_opc_q <= pend_opc_d;
            valid_q    <= valid_d;
            op_q       <= op_d;
            word_q     <= word_d;
            dest_q     <= dest_d;
            modrm_q    <= modrm_d;
            mod_q      <= mod_d;
            reg_q      <= reg_d;
            seg_q      <= seg_d;
            rm_q       <= rm_d;
            ill_q      <= ill_d;
            unk_q      <= unk_d;
        end
    end

    assign dec_valid       = valid_q;
    assign dec_op          = op_q;
    assign dec_word        = word_q;
    assign dec_reg_is_dest = dest_q;
    assign dec_has_modrm   = modrm_q;
    assign dec_mod         = mod_q;
    assign dec_reg         = reg_q;
    assign dec_seg         = seg_q;
    assign dec_rm          = rm_q;
    assign dec_illegal     = ill_q;
    assign dec_unknown     = unk_q;

    property p_seg_from;
        @(posedge clk_sys) disable iff (rst)
        (state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'h8E)
        ##1 (state_q == dtd_pkg::DTD_ST_MODRM && byte_valid)
        |=> dec_valid && dec_op == dtd_pkg::DTD_OP_SEG_FROM_RM && dec_word && dec_reg_is_dest;
    endproperty
    a_seg_from: assert property (p_seg_from) else $error("8E not decoded");

    property p_seg_to;
        @(posedge clk_sys) disable iff (rst)
        (state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'h8C)
        ##1 (state_q == dtd_pkg::DTD_ST_MODRM && byte_valid)
        |=> dec_op == dtd_pkg::DTD_OP_SEG_TO_RM && dec_seg == $past(byte_data[4:3]);
    endproperty
    a_seg_to: assert property (p_seg_to) else $error("8C not decoded");

    property p_lookup;
        @(posedge clk_sys) disable iff (rst)
        state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'hD7
        |=> dec_valid && dec_op == dtd_pkg::DTD_OP_TABLE_LOOKUP && !dec_has_modrm && !dec_word;
    endproperty
    a_lookup: assert property (p_lookup) else $error("D7 not decoded");

    property p_ea;
        @(posedge clk_sys) disable iff (rst)
        (state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'h8D)
        ##1 (byte_valid && state_q == dtd_pkg::DTD_ST_MODRM)
        |=> dec_op == dtd_pkg::DTD_OP_EA_LOAD && dec_reg == $past(byte_data[5:3]);
    endproperty
    a_ea: assert property (p_ea) else $error("8D not decoded");

    property p_lds;
        @(posedge clk_sys) disable iff (rst)
        (state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'hC5)
        ##1 (byte_valid && state_q == dtd_pkg::DTD_ST_MODRM)
        |=> dec_valid && dec_op == dtd_pkg::DTD_OP_PTR_DATA_SEG && dec_word;
    endproperty
    a_lds: assert property (p_lds) else $error("C5 not decoded");

    property p_les;
        @(posedge clk_sys) disable iff (rst)
        (state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'hC4)
        ##1 (byte_valid && state_q == dtd_pkg::DTD_ST_MODRM)
        |=> dec_valid && dec_op == dtd_pkg::DTD_OP_PTR_EXTRA;
    endproperty
    a_les: assert property (p_les) else $error("C4 not decoded");

    property p_flags_to_high_acc;
        @(posedge clk_sys) disable iff (rst)
        state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'h9F
        |=> dec_valid && dec_op == dtd_pkg::DTD_OP_FLAGS_TO_AH && !dec_word;
    endproperty
    a_flags_to_high_acc: assert property (p_flags_to_high_acc) else $error("9F not decoded");

    property p_high_acc_to_flags;
        @(posedge clk_sys) disable iff (rst)
        state_q == dtd_pkg::DTD_ST_OPCODE && byte_valid && byte_data == 8'h9E
        |=> dec_valid && dec_op == dtd_pkg::DTD_OP_AH_TO_FLAGS && !dec_word;
    endproperty
    a_high_acc_to_flags: assert property (p_high_acc_to_flags) else $error("9E not decoded");

    property p_sense;
        @(posedge clk_sys) disable iff (rst)
        dec_valid && dec_has_modrm |-> dec_word &&
            dec_reg_is_dest == (dec_op != dtd_pkg::DTD_OP_SEG_TO_RM);
    endproperty
    a_sense: assert property (p_sense) else $error("sense bit wrong");

    c_two_byte: cover property (@(posedge clk_sys) dec_valid && dec_has_modrm);
    c_one_byte: cover property (@(posedge clk_sys) dec_valid && !dec_has_modrm);
    c_illegal:  cover property (@(posedge clk_sys) dec_illegal);
    c_unknown:  cover property (@(posedge clk_sys) dec_unknown);

endmodule : dtd_decoder

/* verification/dtd_prog_mem.sv */
`timescale 1ns/1ps
module dtd_prog_mem (
    input  wire logic       clk_sys,
    output logic            byte_valid,
    output logic [7:0]      byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'hA5;
    end

    // one byte on the bus from just after an edge until the next edge takes it
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        #1;
        byte_valid = 1'b1;
        byte_data  = b;
    endtask : send

    // released bus inverts the byte it showed, so a second idle in a row shows the last byte again
    task automatic idle();
        @(posedge clk_sys);
        #1;
        byte_valid = 1'b0;
        byte_data  = ~byte_data;
    endtask : idle
endmodule : dtd_prog_mem

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    logic               clk_sys;
    logic               rst;
    logic               byte_valid;
    logic [7:0]         byte_data;
    logic               dec_valid;
    dtd_pkg::dtd_op_t   dec_op;
    logic               dec_word;
    logic               dec_reg_is_dest;
    logic               dec_has_modrm;
    logic [1:0]         dec_mod;
    logic [2:0]         dec_reg;
    logic [1:0]         dec_seg;
    logic [2:0]         dec_rm;
    logic               dec_illegal;
    logic               dec_unknown;
    int                 n_fail;
    int                 cmp_count;

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    dtd_prog_mem i_mem (.clk_sys(clk_sys), .byte_valid(byte_valid), .byte_data(byte_data));

    dtd_decoder i_dut (
        .clk_sys(clk_sys), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
        .dec_valid(dec_valid), .dec_op(dec_op), .dec_word(dec_word),
        .dec_reg_is_dest(dec_reg_is_dest), .dec_has_modrm(dec_has_modrm), .dec_mod(dec_mod),
        .dec_reg(dec_reg), .dec_seg(dec_seg), .dec_rm(dec_rm), .dec_illegal(dec_illegal),
        .dec_unknown(dec_unknown)
    );

    task automatic ce(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : ce

    // two-byte forms move words, single bytes move one accumulator byte;
    // only a copy out of a segment register leaves reg as the source
    task automatic chk(input dtd_pkg::dtd_op_t op, input logic [7:0] opc, input logic has,
                       input logic [7:0] b2, input logic ill);
        logic [7:0] f;
        f = has ? b2 : 8'h00;
        ce({7'h00, dec_valid}, 8'h01);
        ce({4'h0, dec_op}, {4'h0, op});
        ce({7'h00, dec_word}, {7'h00, has});
        ce({7'h00, dec_reg_is_dest}, {7'h00, has & (opc != dtd_pkg::OPC_SEG_TO_RM)});
        ce({7'h00, dec_has_modrm}, {7'h00, has});
        ce({dec_mod, dec_reg, dec_rm}, f);
        ce({6'h00, dec_seg}, {6'h00, f[4:3]});
        ce({6'h00, dec_illegal, dec_unknown}, {6'h00, ill, 1'b0});
    endtask : chk

    task automatic t_idle_zero();
        ce({dec_valid, dec_illegal, dec_unknown, dec_has_modrm, dec_op}, 8'h00);
        ce({dec_mod, dec_reg, dec_rm}, 8'h00);
    endtask : t_idle_zero

    task automatic t_all_ops();
        logic [7:0]       opc [8] = '{8'h8E, 8'h8C, 8'hD7, 8'h8D, 8'hC5, 8'hC4, 8'h9F, 8'h9E};
        logic [7:0]       b2  [8] = '{8'h18, 8'h46, 8'h00, 8'h8B, 8'h7F, 8'h05, 8'h00, 8'h00};
        logic             has [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 8; i++) begin
            i_mem.send(opc[i]);
            if (has[i]) i_mem.send(b2[i]);
            i_mem.idle();
            chk(dtd_pkg::dtd_op_t'(i + 1), opc[i], has[i], b2[i], 1'b0);
        end
    endtask : t_all_ops

    task automatic t_back_to_back();
        i_mem.send(dtd_pkg::OPC_SEG_FROM_RM);
        i_mem.send(8'hD8);
        i_mem.send(dtd_pkg::OPC_TABLE_LOOKUP);
        chk(dtd_pkg::DTD_OP_SEG_FROM_RM, 8'h8E, 1'b1, 8'hD8, 1'b0);
        i_mem.idle();
        chk(dtd_pkg::DTD_OP_TABLE_LOOKUP, 8'hD7, 1'b0, 8'h00, 1'b0);
    endtask : t_back_to_back

    task automatic t_illegal();
        logic [7:0]       opc [4] = '{8'h8E, 8'h8C, 8'h8D, 8'hC4};
        logic [7:0]       b2  [4] = '{8'h20, 8'hE8, 8'hC1, 8'hFF};
        dtd_pkg::dtd_op_t op  [4] = '{dtd_pkg::DTD_OP_SEG_FROM_RM, dtd_pkg::DTD_OP_SEG_TO_RM,
                                      dtd_pkg::DTD_OP_EA_LOAD, dtd_pkg::DTD_OP_PTR_EXTRA};
        for (int i = 0; i < 4; i++) begin
            i_mem.send(opc[i]);
            i_mem.send(b2[i]);
            i_mem.idle();
            chk(op[i], opc[i], 1'b1, b2[i], 1'b1);
        end
    endtask : t_illegal

    task automatic t_unknown();
        i_mem.send(8'h9C);
        i_mem.idle();
        ce({6'h00, dec_valid, dec_unknown}, 8'h01);
        i_mem.send(dtd_pkg::OPC_AH_TO_FLAGS);
        i_mem.idle();
        chk(dtd_pkg::DTD_OP_AH_TO_FLAGS, 8'h9E, 1'b0, 8'h00, 1'b0);
    endtask : t_unknown

    // slow memory: the addressing byte arrives after a pause
    task automatic t_gap();
        i_mem.send(dtd_pkg::OPC_PTR_EXTRA);
        for (int i = 0; i < 3; i++) begin
            i_mem.idle();
            ce({7'h00, dec_valid}, 8'h00);
        end
        i_mem.send(8'h12);
        i_mem.idle();
        chk(dtd_pkg::DTD_OP_PTR_EXTRA, 8'hC4, 1'b1, 8'h12, 1'b0);
    endtask : t_gap

    // a reset between opcode and addressing byte must drop the pending opcode
    task automatic t_mid_reset();
        i_mem.send(dtd_pkg::OPC_PTR_DATA_SEG);
        i_mem.idle();
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_idle_zero();
        i_mem.send(dtd_pkg::OPC_TABLE_LOOKUP);
        i_mem.idle();
        chk(dtd_pkg::DTD_OP_TABLE_LOOKUP, 8'hD7, 1'b0, 8'h00, 1'b0);
    endtask : t_mid_reset

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end

    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_idle_zero();
        t_all_ops();
        t_back_to_back();
        t_illegal();
        t_unknown();
        t_gap();
        t_mid_reset();
        report_and_stop();
    end
endmodule : tb
